// *** verilog/charger_step_thermal_config.sv ***
// Step-charge and thermal-zone configuration bank with its decoded effective limits.
// Assumes a same-clock byte register port and a raw charger presence pin.
`default_nettype none
// Summary of operation
// - Marked fields return to defaults on presence edges chosen by detect option.
// - Undervoltage selector 00..11 decodes to 2.7, 2.9, 3.0, 3.2 V.
// - Above step threshold, step fraction 0.2..0.8 by tenths, 111 full.
// - Effective current is smaller of step and active zone reductions.
// - Thermistor enable field picks which zones allow charging.
// - Thermistor enable ignored when no charger input present.
// - Cool zone lowers regulation by 150, 100, 50 or 0 mV.
// - Cool zone scales current by its fraction field.
// - Room zone lowers regulation by 150, 100, 50 or 0 mV.
// - Room zone scales current by its fraction field.
// - Warm fraction uses same encoding and joins minimum selection.
// - Base regulation is 4.05 V plus 50 mV per code step.
module charger_step_thermal_config
	import chg_cfg_pkg::*;
(
	input  wire logic        ref_clk_in,       // 20 MHz register clock
	input  wire logic        rst_n_in,         // Async active-low reset
	input  wire logic [7:0]  reg_addr_in,      // Register address
	input  wire logic        reg_wr_in,        // Write strobe
	input  wire logic        reg_rd_in,        // Read strobe
	input  wire logic [7:0]  reg_wdata_in,     // Write data
	output logic      [7:0]  reg_rdata_out,    // Registered read data
	output logic             reg_rvalid_out,   // Read data valid pulse
	input  wire logic        supply_pin_in,    // Charger input presence pin
	input  wire logic [1:0]  input_detect_option_in, // Edge select
	input  wire logic [3:0]  base_regulation_voltage_in, // Base code
	input  wire logic        step_rising_threshold_in, // Battery above step threshold
	input  wire logic [2:0]  warm_current_fraction_in, // Warm zone code
	input  wire logic [1:0]  zone_in,          // Active thermistor zone
	output logic      [11:0] uvlo_mv_out,      // Undervoltage threshold mV
	output logic      [3:0]  current_tenths_out, // Effective fraction
	output logic      [12:0] regulation_mv_out, // Effective regulation mV
	output logic             charge_allowed_out, // Zone permits charging
	output logic             monitor_on_out,   // Thermistor monitoring active
	output logic      [16:0] cfg_out           // Packed configuration
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] step_q, therm_a_q, therm_b_q;
	logic       sync1_q, sync2_q, prev_q;
	logic [7:0] rdata_d;
	logic [3:0] step_t, cool_t, room_t, warm_t, zone_t, lim_t;
	logic [12:0] base_mv, drop_mv;
	logic       rise, fall, restore;
	cfg_s       cfg;
	zone_e      zone;

	// Zone voltage drop; shared by cool and room so both decode alike
	function automatic logic [12:0] drop_of(input logic [1:0] sel);
		unique case (sel)
			2'h0: drop_of = DROP_150_MV;
			2'h1: drop_of = DROP_100_MV;
			2'h2: drop_of = DROP_50_MV;
			2'h3: drop_of = DROP_0_MV;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Presence synchroniser and plug edges
	// ------------------------------------------------------------
	// A supply already present at reset release looks like a rise; it only restores defaults

	// Presence pin crosses into the clock domain; only the second stage is read
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= supply_pin_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign rise = sync2_q & ~prev_q;
	assign fall = ~sync2_q & prev_q;
	// Edge selection by the detect option
	always_comb begin
		unique case (input_detect_option_in)
			DET_BOTH: restore = rise | fall;
			DET_RISE: restore = rise;
			DET_FALL: restore = fall;
			DET_NONE: restore = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Restore takes priority over a same-cycle host write: defaults must hold after plug events
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			step_q    <= STEP_CFG_B_RST;
			therm_a_q <= THERM_CFG_A_RST;
			therm_b_q <= THERM_CFG_B_RST;
		end else if (restore) begin
			step_q    <= STEP_CFG_B_RST;
			therm_a_q <= THERM_CFG_A_RST;
			therm_b_q <= THERM_CFG_B_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == STEP_CFG_B_OFS)
				step_q <= reg_wdata_in & STEP_CFG_B_MASK;
			if (reg_addr_in == THERM_CFG_A_OFS)
				therm_a_q <= reg_wdata_in & THERM_CFG_A_MASK;
			if (reg_addr_in == THERM_CFG_B_OFS)
				therm_b_q <= reg_wdata_in & THERM_CFG_B_MASK;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Read mux; unmapped addresses return zero
	always_comb begin
		rdata_d = 8'h00;
		unique case (reg_addr_in)
			STEP_CFG_B_OFS:  rdata_d = step_q & STEP_CFG_B_MASK;
			THERM_CFG_A_OFS: rdata_d = therm_a_q & THERM_CFG_A_MASK;
			THERM_CFG_B_OFS: rdata_d = therm_b_q & THERM_CFG_B_MASK;
			default:         rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in)
				reg_rdata_out <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	assign cfg.step_frac = step_q[FRAC_MSB:FRAC_LSB];
	assign cfg.uvlo_sel  = step_q[OFS_MSB:OFS_LSB];
	assign cfg.therm_en  = therm_a_q[TEN_MSB:TEN_LSB];
	assign cfg.cool_ofs  = therm_a_q[OFS_MSB:OFS_LSB];
	assign cfg.cool_frac = therm_a_q[FRAC_MSB:FRAC_LSB];
	assign cfg.room_ofs  = therm_b_q[OFS_MSB:OFS_LSB];
	assign cfg.room_frac = therm_b_q[FRAC_MSB:FRAC_LSB];
	assign cfg_out = cfg;
	assign zone = zone_e'(zone_in);

	// Undervoltage threshold selector
	always_comb begin
		unique case (cfg.uvlo_sel)
			2'h0: uvlo_mv_out = UVLO_2V7_MV;
			2'h1: uvlo_mv_out = UVLO_2V9_MV;
			2'h2: uvlo_mv_out = UVLO_3V0_MV;
			2'h3: uvlo_mv_out = UVLO_3V2_MV;
		endcase
	end

	// ------------------------------------------------------------
	// Current and voltage limits
	// ------------------------------------------------------------
	// One decoder per fraction field keeps the four encodings identical
	frac_decode u_step (
		.code_in    (cfg.step_frac),
		.tenths_out (step_t)
	);
	frac_decode u_cool (
		.code_in    (cfg.cool_frac),
		.tenths_out (cool_t)
	);
	frac_decode u_room (
		.code_in    (cfg.room_frac),
		.tenths_out (room_t)
	);
	frac_decode u_warm (
		.code_in    (warm_current_fraction_in),
		.tenths_out (warm_t)
	);

	// Monitoring only counts with a charger present
	assign monitor_on_out = sync2_q && (cfg.therm_en != 2'h0);

	// Zone permission per enable field
	always_comb begin
		charge_allowed_out = 1'b1;
		if (monitor_on_out) begin
			unique case (zone)
				ZONE_COOL: charge_allowed_out = cfg.therm_en[0];
				ZONE_ROOM: charge_allowed_out = 1'b1;
				ZONE_WARM: charge_allowed_out = cfg.therm_en[1];
				ZONE_COLD: charge_allowed_out = 1'b0;
			endcase
		end
	end

	// Zone reductions; outside monitoring no zone limit applies
	always_comb begin
		zone_t  = FRAC_FULL_TEN;
		drop_mv = 13'h0000;
		if (monitor_on_out) begin
			unique case (zone)
				ZONE_COOL: begin
					zone_t  = cool_t;
					drop_mv = drop_of(cfg.cool_ofs);
				end
				ZONE_ROOM: begin
					zone_t  = room_t;
					drop_mv = drop_of(cfg.room_ofs);
				end
				ZONE_WARM: zone_t = warm_t;
				ZONE_COLD: zone_t = FRAC_FULL_TEN;
			endcase
		end
	end

	assign lim_t = step_rising_threshold_in ? step_t : FRAC_FULL_TEN;
	assign current_tenths_out = (lim_t < zone_t) ? lim_t : zone_t;
	// Base regulation: 4.05 V plus 50 mV per step
	assign base_mv = BASE_REG_MV + 13'(BASE_STEP_MV * {9'h000, base_regulation_voltage_in});
	assign regulation_mv_out = base_mv - drop_mv;
endmodule // charger_step_thermal_config
`default_nettype wire

// *** common/chg_cfg_pkg.sv ***
// Constants and carrier types for the step-charge and thermal configuration bank.
// Assumes a byte-wide register access port driven by the serial configuration front end.
`default_nettype none
package chg_cfg_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] STEP_CFG_B_OFS  = 8'h14;
	localparam logic [7:0] THERM_CFG_A_OFS = 8'h15;
	localparam logic [7:0] THERM_CFG_B_OFS = 8'h16;
	localparam logic [7:0] STEP_CFG_B_MASK  = 8'h1F;
	localparam logic [7:0] THERM_CFG_A_MASK = 8'h7F;
	localparam logic [7:0] THERM_CFG_B_MASK = 8'h1F;
	// Reset values are not printed; neutral defaults
	localparam logic [7:0] STEP_CFG_B_RST  = 8'h07;
	localparam logic [7:0] THERM_CFG_A_RST = 8'h1F;
	localparam logic [7:0] THERM_CFG_B_RST = 8'h1F;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FRAC_LSB = 0;
	localparam int FRAC_MSB = 2;
	localparam int OFS_LSB  = 3;
	localparam int OFS_MSB  = 4;
	localparam int TEN_LSB  = 5;
	localparam int TEN_MSB  = 6;
	// ------------------------------------------------------------
	// Encodings, in millivolts and tenths
	// ------------------------------------------------------------
	localparam logic [11:0] UVLO_2V7_MV   = 12'hA8C;
	localparam logic [11:0] UVLO_2V9_MV   = 12'hB54;
	localparam logic [11:0] UVLO_3V0_MV   = 12'hBB8;
	localparam logic [11:0] UVLO_3V2_MV   = 12'hC80;
	localparam logic [12:0] BASE_REG_MV   = 13'h0FD2;  // 4.05 V
	localparam logic [12:0] BASE_STEP_MV  = 13'h0032;  // 50 mV
	localparam logic [12:0] DROP_150_MV   = 13'h0096;  // Zone drop code 00
	localparam logic [12:0] DROP_100_MV   = 13'h0064;  // Zone drop code 01
	localparam logic [12:0] DROP_50_MV    = 13'h0032;  // Zone drop code 10
	localparam logic [12:0] DROP_0_MV     = 13'h0000;  // Zone drop code 11
	localparam logic [3:0]  FRAC_MIN_TEN  = 4'h2;      // 0.2
	localparam logic [3:0]  FRAC_FULL_TEN = 4'hA;      // 1.0
	localparam logic [2:0]  FRAC_FULL_CODE = 3'h7;
	localparam logic [1:0]  DET_BOTH = 2'h0;
	localparam logic [1:0]  DET_RISE = 2'h1;
	localparam logic [1:0]  DET_FALL = 2'h2;
	localparam logic [1:0]  DET_NONE = 2'h3;
	typedef enum logic [1:0] {ZONE_COLD = 2'h0, ZONE_COOL = 2'h1,
		ZONE_ROOM = 2'h3, ZONE_WARM = 2'h2} zone_e;
	typedef struct packed {
		logic [2:0] step_frac;
		logic [1:0] uvlo_sel;
		logic [1:0] therm_en;
		logic [1:0] cool_ofs;
		logic [2:0] cool_frac;
		logic [1:0] room_ofs;
		logic [2:0] room_frac;
	} cfg_s;
endpackage
`default_nettype wire

// *** verilog/frac_decode.sv ***
// Decodes a three-bit current fraction code into tenths of full current.
// Pure combinational leaf used once per zone and step field.
`default_nettype none
module frac_decode
	import chg_cfg_pkg::*;
(
	input  wire logic [2:0] code_in,   // Fraction code
	output logic      [3:0] tenths_out // Fraction in tenths
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Codes below seven are linear; seven jumps to full current
	assign tenths_out = (code_in == FRAC_FULL_CODE) ? FRAC_FULL_TEN :
		FRAC_MIN_TEN + {1'b0, code_in};
endmodule // frac_decode
`default_nettype wire

// *** dv/chg_cfg_assertions.sv ***
// Port checker for the step-charge and thermal configuration bank.
// Assumes a bind onto the bank's top module.
`default_nettype none
module chg_cfg_checker
	import chg_cfg_pkg::*;
(
	input wire logic        ref_clk_in,                 // Clock
	input wire logic        rst_n_in,                   // Reset
	input wire logic [7:0]  reg_addr_in,                // Address
	input wire logic        reg_rd_in,                  // Read
	input wire logic [7:0]  reg_rdata_out,              // Data
	input wire logic        reg_rvalid_out,             // Valid
	input wire logic        supply_pin_in,              // Supply
	input wire logic [3:0]  base_regulation_voltage_in, // Base
	input wire logic        step_rising_threshold_in,   // Step
	input wire logic [2:0]  warm_current_fraction_in,   // Warm
	input wire logic [1:0]  zone_in,                    // Zone
	input wire logic [11:0] uvlo_mv_out,                // Threshold
	input wire logic [3:0]  current_tenths_out,         // Current
	input wire logic [12:0] regulation_mv_out,          // Voltage
	input wire logic        charge_allowed_out,         // Allow
	input wire logic        monitor_on_out              // Monitor
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Three low samples let the two-flop synchroniser settle
	sequence s_no_supply;
		!supply_pin_in ##1 !supply_pin_in ##1 !supply_pin_in;
	endsequence
	sequence s_answer_from(logic [7:0] a);
		reg_rvalid_out && $past(reg_addr_in) == a;
	endsequence
	AST_READ_ANSWER:
	assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
	AST_UPPER_ZERO:
	assert property (s_answer_from(STEP_CFG_B_OFS) |-> reg_rdata_out[7:5] == 3'h0)
		else $error("upper bits not zero");
	AST_UNMAPPED_ZERO:
	assert property (reg_rvalid_out && !($past(reg_addr_in) inside {[8'h14:8'h16]})
		|-> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	AST_UVLO_DECODE:
	assert property (s_answer_from(STEP_CFG_B_OFS) |-> uvlo_mv_out == (reg_rdata_out[4] ?
		(reg_rdata_out[3] ? UVLO_3V2_MV : UVLO_3V0_MV) :
		(reg_rdata_out[3] ? UVLO_2V9_MV : UVLO_2V7_MV))) else $error("threshold wrong");
	AST_NO_LIMIT:
	assert property (!monitor_on_out && !step_rising_threshold_in |->
		current_tenths_out == FRAC_FULL_TEN) else $error("current limited");
	AST_MONITOR_OFF_ALLOWS:
	assert property (!monitor_on_out |-> charge_allowed_out) else $error("charge blocked");
	AST_COLD_BLOCKS:
	assert property (monitor_on_out && zone_in == ZONE_COLD |-> !charge_allowed_out)
		else $error("cold charge allowed");
	AST_SUPPLY_GONE:
	assert property (s_no_supply |-> !monitor_on_out) else $error("monitor without supply");
	AST_BASE_VOLTAGE:
	assert property (!monitor_on_out |-> regulation_mv_out ==
		BASE_REG_MV + BASE_STEP_MV * base_regulation_voltage_in) else $error("base wrong");
	AST_WARM_LIMIT:
	assert property (monitor_on_out && zone_in == ZONE_WARM && !step_rising_threshold_in
		|-> current_tenths_out == ((warm_current_fraction_in == 3'h7) ? FRAC_FULL_TEN :
		warm_current_fraction_in + FRAC_MIN_TEN)) else $error("warm limit wrong");
endmodule // chg_cfg_checker
bind charger_step_thermal_config chg_cfg_checker u_chk (
	.ref_clk_in                 (ref_clk_in),
	.rst_n_in                   (rst_n_in),
	.reg_addr_in                (reg_addr_in),
	.reg_rd_in                  (reg_rd_in),
	.reg_rdata_out              (reg_rdata_out),
	.reg_rvalid_out             (reg_rvalid_out),
	.supply_pin_in              (supply_pin_in),
	.base_regulation_voltage_in (base_regulation_voltage_in),
	.step_rising_threshold_in   (step_rising_threshold_in),
	.warm_current_fraction_in   (warm_current_fraction_in),
	.zone_in                    (zone_in),
	.uvlo_mv_out                (uvlo_mv_out),
	.current_tenths_out         (current_tenths_out),
	.regulation_mv_out          (regulation_mv_out),
	.charge_allowed_out         (charge_allowed_out),
	.monitor_on_out             (monitor_on_out)
);
`default_nettype wire

// *** dv/cfg_host_model.sv ***
// Host side of the byte register port.
// Assumes the bank answers a read one cycle after it is taken.
`default_nettype none
module cfg_host_model (
	input  wire logic       ref_clk_in,    // Clock
	input  wire logic [7:0] reg_rdata_in,  // Read data
	input  wire logic       reg_rvalid_in, // Read valid
	output logic      [7:0] reg_addr_out,  // Address
	output logic            reg_wr_out,    // Write
	output logic            reg_rd_out,    // Read
	output logic      [7:0] reg_wdata_out  // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle port; strobes move only on falling edges, clear of sampling
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_wdata_out = 8'h00;
	end
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge ref_clk_in);
		reg_wr_out = 1'b0;
	endtask
	// Valid stands one cycle, so it is sampled at the next falling edge
	task automatic read_reg(input logic [7:0] a, output logic [8:0] d);
		@(negedge ref_clk_in);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge ref_clk_in);
		reg_rd_out = 1'b0;
		d = {reg_rvalid_in, reg_rdata_in};
	endtask
endmodule // cfg_host_model
`default_nettype wire

// *** dv/tb_charger_step_thermal_config.sv ***
// Self-checking bench for the configuration bank.
// Assumes the host model and checker are compiled first.
`default_nettype none
module tb_charger_step_thermal_config
	import chg_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out, supply_pin_in;
	logic step_rising_threshold_in, charge_allowed_out, monitor_on_out;
	logic [1:0] input_detect_option_in, zone_in;
	logic [2:0] warm_current_fraction_in;
	logic [3:0] base_regulation_voltage_in, current_tenths_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [11:0] uvlo_mv_out;
	logic [12:0] regulation_mv_out, bv;
	logic [16:0] cfg_out;
	int n_mismatch, checks_done, cyc;
	logic [11:0] uvt [4] = '{UVLO_2V7_MV, UVLO_2V9_MV, UVLO_3V0_MV, UVLO_3V2_MV};
	logic [3:0] alt [4] = '{4'hF, 4'hA, 4'hC, 4'hE}; // Allowed zones per enable code
	charger_step_thermal_config dut (
		.ref_clk_in                 (ref_clk_in),
		.rst_n_in                   (rst_n_in),
		.reg_addr_in                (reg_addr_in),
		.reg_wr_in                  (reg_wr_in),
		.reg_rd_in                  (reg_rd_in),
		.reg_wdata_in               (reg_wdata_in),
		.reg_rdata_out              (reg_rdata_out),
		.reg_rvalid_out             (reg_rvalid_out),
		.supply_pin_in              (supply_pin_in),
		.input_detect_option_in     (input_detect_option_in),
		.base_regulation_voltage_in (base_regulation_voltage_in),
		.step_rising_threshold_in   (step_rising_threshold_in),
		.warm_current_fraction_in   (warm_current_fraction_in),
		.zone_in                    (zone_in),
		.uvlo_mv_out                (uvlo_mv_out),
		.current_tenths_out         (current_tenths_out),
		.regulation_mv_out          (regulation_mv_out),
		.charge_allowed_out         (charge_allowed_out),
		.monitor_on_out             (monitor_on_out),
		.cfg_out                    (cfg_out)
	);
	cfg_host_model host (.ref_clk_in(ref_clk_in), .reg_rdata_in(reg_rdata_out),
		.reg_rvalid_in(reg_rvalid_out), .reg_addr_out(reg_addr_in),
		.reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in));
	// Clock and a hang guard far above the few hundred cycles needed
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [8:0] d;
		host.read_reg(a, d);
		chk("rdata", {5'h01, e}, {4'h0, d});
	endtask
	function automatic logic [3:0] fr(input logic [2:0] c);
		return (c == 3'h7) ? FRAC_FULL_TEN : {1'b0, c} + FRAC_MIN_TEN;
	endfunction
	// Writes a non-default value, then moves the supply under one option
	task automatic edge_chk(input logic [1:0] o, input logic s, input logic [7:0] e);
		host.write_reg(THERM_CFG_A_OFS, 8'h7F);
		input_detect_option_in = o;
		supply_pin_in = s;
		repeat (4) @(negedge ref_clk_in);
		rdc(THERM_CFG_A_OFS, e);
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst_n_in, supply_pin_in, input_detect_option_in, zone_in} = '0;
		base_regulation_voltage_in = 4'h3;
		step_rising_threshold_in = 1'b1;
		warm_current_fraction_in = 3'h5;
		bv = BASE_REG_MV + BASE_STEP_MV * 13'h3;
		repeat (5) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		rdc(STEP_CFG_B_OFS, STEP_CFG_B_RST);
		rdc(THERM_CFG_A_OFS, THERM_CFG_A_RST);
		rdc(THERM_CFG_B_OFS, THERM_CFG_B_RST);
		host.write_reg(8'h20, 8'hAA);
		rdc(8'h20, 8'h00);
		for (int i = 0; i < 3; i++) begin
			host.write_reg({6'h05, i[1:0]}, 8'hFF);
			rdc({6'h05, i[1:0]}, (i == 1) ? 8'h7F : 8'h1F);
		end
		for (int i = 0; i < 8; i++) begin
			base_regulation_voltage_in = 4'(i);
			host.write_reg(STEP_CFG_B_OFS, {3'h0, i[1:0], i[2:0]});
			chk("uvlo", {1'b0, uvt[i[1:0]]}, {1'b0, uvlo_mv_out});
			chk("step", fr(i[2:0]), current_tenths_out);
			chk("base_v", BASE_REG_MV + BASE_STEP_MV * 13'(i), regulation_mv_out);
			rdc(STEP_CFG_B_OFS, {3'h0, i[1:0], i[2:0]});
		end
		base_regulation_voltage_in = 4'h3;
		supply_pin_in = 1'b1;
		step_rising_threshold_in = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		for (int i = 0; i < 8; i++) begin
			host.write_reg(THERM_CFG_A_OFS, {3'h3, i[1:0], i[2:0]});
			host.write_reg(THERM_CFG_B_OFS, {3'h0, ~i[1:0], ~i[2:0]});
			zone_in = ZONE_COOL;
			@(negedge ref_clk_in);
			chk("cool_i", fr(i[2:0]), current_tenths_out);
			chk("cool_v", bv - 13'h096 + 13'h032 * i[1:0], regulation_mv_out);
			zone_in = ZONE_ROOM;
			@(negedge ref_clk_in);
			chk("room_i", fr(~i[2:0]), current_tenths_out);
			chk("room_v", bv - 13'h096 + 13'h032 * {~i[1:0]}, regulation_mv_out);
		end
		step_rising_threshold_in = 1'b1;
		zone_in = ZONE_COOL;
		host.write_reg(STEP_CFG_B_OFS, 8'h03);
		host.write_reg(THERM_CFG_A_OFS, 8'h61);
		chk("min_zone", 13'h3, current_tenths_out);
		host.write_reg(THERM_CFG_A_OFS, 8'h66);
		chk("min_step", 13'h5, current_tenths_out);
		chk("cfg", {3'h3, 2'h0, 2'h3, 2'h0, 3'h6, 2'h0, 3'h0}, cfg_out);
		step_rising_threshold_in = 1'b0;
		for (int i = 0; i < 16; i++) begin
			host.write_reg(THERM_CFG_A_OFS, {1'b0, i[3:2], 5'h1F});
			zone_in = i[1:0];
			@(negedge ref_clk_in);
			chk("allow", alt[i[3:2]][i[1:0]], charge_allowed_out);
			chk("monitor", i[3:2] != 2'h0, monitor_on_out);
		end
		edge_chk(DET_NONE, 1'b0, 8'h7F);
		chk("monitor", 13'h0, monitor_on_out);
		edge_chk(DET_RISE, 1'b1, 8'h1F);
		edge_chk(DET_RISE, 1'b0, 8'h7F);
		edge_chk(DET_FALL, 1'b1, 8'h7F);
		edge_chk(DET_FALL, 1'b0, 8'h1F);
		edge_chk(DET_BOTH, 1'b1, 8'h1F);
		summarize();
	end
endmodule // tb_charger_step_thermal_config
`default_nettype wire
